// *** rtl/psi_status_regs.sv ***
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - bit 15 always reads zero
// - bits 14 to 11 always read zero
// - preamble suppression; 32 ones after reset/errors
// - negotiation complete bit reads one
// - remote fault latches high, clears on read
// - negotiation ability bit reads zero
// - link bit latches low until read
// - jabber bit latches high until read
// - extended capability bit reads one
// - upper identifier holds organization bits 21:6
// - lower identifier: organization, model, revision
// - latched-high bits hold until read
// - latched-low bits hold low until read, then reload from link_up
module psi_status_regs #(
  parameter logic [psi_pkg::OUI_W-1:0]   OUI_VALUE   = 22'h2a5a5c,
  parameter logic [psi_pkg::MODEL_W-1:0] MODEL_VALUE = 6'h1c,
  parameter logic [psi_pkg::REV_W-1:0]   REV_VALUE   = 4'h7,
  parameter int unsigned                 ADDR_W      = psi_pkg::PHY_ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              mdc,
  input  wire logic              mdio_in,
  output var  logic              mdio_out,
  output var  logic              mdio_oe,
  input  wire logic [ADDR_W-1:0] phy_addr_strap,
  input  wire logic              sw_clear,
  input  wire logic              link_up,
  input  wire logic              remote_fault,
  input  wire logic              jabber
);
  import psi_pkg::*;
  if (ADDR_W < 1 || ADDR_W > 5)
  begin
    $error("phy address width must be 1 to 5");
  end

  // ******************************************************
  // reset and input synchronisers
  // ******************************************************
  logic              rst_s1;
  logic              rst_sync_n;
  logic              mdc_s1;
  logic              mdc_s2;
  logic              mdc_s3;
  logic              mdio_s1;
  logic              mdio_s2;
  logic [ADDR_W-1:0] strap_s1;
  logic [ADDR_W-1:0] strap_s2;
  logic [1:0]        cap_cnt_reg;
  logic [ADDR_W-1:0] phy_addr_reg;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1     <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1     <= 1'b1;
      rst_sync_n <= rst_s1;
    end
  end

  // strap is caught once, after the synchroniser has filled
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      mdc_s1       <= 1'b0;
      mdc_s2       <= 1'b0;
      mdc_s3       <= 1'b0;
      mdio_s1      <= 1'b1;
      mdio_s2      <= 1'b1;
      strap_s1     <= '0;
      strap_s2     <= '0;
      cap_cnt_reg  <= 2'h0;
      phy_addr_reg <= '0;
    end
    else
    begin
      mdc_s1   <= mdc;
      mdc_s2   <= mdc_s1;
      mdc_s3   <= mdc_s2;
      mdio_s1  <= mdio_in;
      mdio_s2  <= mdio_s1;
      strap_s1 <= phy_addr_strap;
      strap_s2 <= strap_s1;
      if (cap_cnt_reg != 2'h3)
        cap_cnt_reg <= cap_cnt_reg + 2'h1;
      if (cap_cnt_reg == 2'h2)
        phy_addr_reg <= strap_s2;
    end
  end
  // ******************************************************
  // management frame engine
  // ******************************************************
  psi_reg_if  reg_bus ();
  psi_state_t  state_reg;
  psi_state_t  state_next;
  logic [5:0]  cnt_reg;
  logic [5:0]  cnt_next;
  logic        pre_ok_reg;
  logic        pre_ok_next;
  logic [11:0] hdr_reg;
  logic [11:0] hdr_next;
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic        is_read_reg;
  logic        is_read_next;
  logic        mine_reg;
  logic        mine_next;
  logic        ta_first_reg;
  logic        ta_first_next;
  logic        rd_stb_reg;
  logic        rd_stb_next;
  logic        out_next;
  logic        oe_next;
  logic        mdc_rise;
  logic        bit_in;
  logic [11:0] hdr_full;
  logic [1:0]  hdr_op;
  logic        op_valid;
  logic        addr_match;
  logic        drive;
  assign mdc_rise   = mdc_s2 & ~mdc_s3;
  assign bit_in     = mdio_s2;
  assign hdr_full   = {hdr_reg[10:0], bit_in};
  assign hdr_op     = hdr_full[11:10];
  assign op_valid   = (hdr_op == OP_READ) || (hdr_op == OP_WRITE);
  assign addr_match = hdr_full[9:5] == 5'(phy_addr_reg);
  assign drive      = is_read_reg & mine_reg;
  assign reg_bus.rd_stb = rd_stb_reg;
  assign reg_bus.addr   = hdr_reg[4:0];
  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    pre_ok_next   = pre_ok_reg;
    hdr_next      = hdr_reg;
    shift_next    = shift_reg;
    is_read_next  = is_read_reg;
    mine_next     = mine_reg;
    ta_first_next = ta_first_reg;
    rd_stb_next   = 1'b0;
    out_next      = mdio_out;
    oe_next       = mdio_oe;
    // read data is snapshotted the cycle the bank sees the strobe
    if (rd_stb_reg)
      shift_next = reg_bus.rdata;
    if (mdc_rise)
    begin
      unique case (state_reg)
        PSI_IDLE:
        begin
          if (bit_in && !pre_ok_reg)
          begin
            if (cnt_reg == PREAMBLE_LEN - 6'h01)
              pre_ok_next = 1'b1;
            cnt_next = cnt_reg + 6'h01;
          end
          else if (!bit_in && pre_ok_reg)
            state_next = PSI_START;
          else if (!bit_in)
            cnt_next = 6'h00;
        end
        PSI_START:
        begin
          cnt_next   = 6'h00;
          state_next = bit_in ? PSI_HDR : PSI_IDLE;
        end
        PSI_HDR:
        begin
          hdr_next = hdr_full;
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == HDR_BITS - 6'h01)
          begin
            cnt_next = 6'h00;
            if (!op_valid)
            begin
              pre_ok_next = 1'b0;
              state_next  = PSI_IDLE;
            end
            else
            begin
              state_next   = PSI_TA;
              is_read_next = hdr_op == OP_READ;
              mine_next    = addr_match;
              rd_stb_next  = (hdr_op == OP_READ) && addr_match;
            end
          end
        end
        PSI_TA:
        begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == 6'h00)
          begin
            ta_first_next = bit_in;
            oe_next       = drive;
            out_next      = 1'b0;
          end
          else if (!is_read_reg && {ta_first_reg, bit_in} != TA_WRITE)
          begin
            pre_ok_next = 1'b0;
            cnt_next    = 6'h00;
            state_next  = PSI_IDLE;
          end
          else
          begin
            cnt_next   = 6'h00;
            state_next = PSI_DATA;
            if (drive)
            begin
              out_next   = shift_reg[15];
              shift_next = {shift_reg[14:0], 1'b0};
            end
          end
        end
        PSI_DATA:
        begin
          cnt_next = cnt_reg + 6'h01;
          if (cnt_reg == DATA_BITS - 6'h01)
          begin
            // write data is dropped: nothing here is writable
            cnt_next   = 6'h00;
            oe_next    = 1'b0;
            state_next = PSI_IDLE;
          end
          else if (drive)
          begin
            out_next   = shift_reg[15];
            shift_next = {shift_reg[14:0], 1'b0};
          end
        end
        default:
        begin
          cnt_next   = 6'h00;
          oe_next    = 1'b0;
          state_next = PSI_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_reg    <= PSI_IDLE;
      cnt_reg      <= 6'h00;
      pre_ok_reg   <= 1'b0;
      hdr_reg      <= 12'h000;
      shift_reg    <= 16'h0000;
      is_read_reg  <= 1'b0;
      mine_reg     <= 1'b0;
      ta_first_reg <= 1'b0;
      rd_stb_reg   <= 1'b0;
      mdio_out     <= 1'b0;
      mdio_oe      <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      pre_ok_reg   <= pre_ok_next;
      hdr_reg      <= hdr_next;
      shift_reg    <= shift_next;
      is_read_reg  <= is_read_next;
      mine_reg     <= mine_next;
      ta_first_reg <= ta_first_next;
      rd_stb_reg   <= rd_stb_next;
      mdio_out     <= out_next;
      mdio_oe      <= oe_next;
    end
  end
  // ******************************************************
  // register bank
  // ******************************************************
  psi_bank #(
    .OUI_VALUE   (OUI_VALUE),
    .MODEL_VALUE (MODEL_VALUE),
    .REV_VALUE   (REV_VALUE)
  ) u_bank (
    .mclk         (mclk),
    .rst_n        (rst_sync_n),
    .sw_clear     (sw_clear),
    .link_up      (link_up),
    .remote_fault (remote_fault),
    .jabber       (jabber),
    .bus          (reg_bus.bank)
  );
endmodule

`default_nettype wire

// *** rtl/psi_pkg.sv ***
package psi_pkg;

  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [4:0] ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] ADDR_ID_UPPER     = 5'h02;
  localparam logic [4:0] ADDR_ID_LOWER     = 5'h03;

  // ******************************************************
  // basic status field positions
  // ******************************************************
  localparam int unsigned BS_PRE_SUPP_BIT = 6;
  localparam int unsigned BS_NEG_DONE_BIT = 5;
  localparam int unsigned BS_RFAULT_BIT   = 4;
  localparam int unsigned BS_LINK_BIT     = 2;
  localparam int unsigned BS_JABBER_BIT   = 1;
  localparam int unsigned BS_EXT_CAP_BIT  = 0;

  // constant part: bits 15..11, 10..7 and 3 read zero
  localparam logic [15:0] BS_FIXED_ZERO_MASK = 16'hff88;

  // ******************************************************
  // latched bit reset values
  // ******************************************************
  localparam logic RFAULT_RST = 1'b0;
  localparam logic LINK_RST   = 1'b1;
  localparam logic JABBER_RST = 1'b0;

  // ******************************************************
  // identifier layout
  // ******************************************************
  localparam int unsigned OUI_W      = 22;
  localparam int unsigned MODEL_W    = 6;
  localparam int unsigned REV_W      = 4;
  localparam int unsigned OUI_HI_MSB = 21;
  localparam int unsigned OUI_HI_LSB = 6;
  localparam int unsigned OUI_LO_MSB = 5;

  // ******************************************************
  // management frame
  // ******************************************************
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_BITS     = 6'h0c;
  localparam logic [5:0] DATA_BITS    = 6'h10;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [1:0] TA_WRITE     = 2'h2;
  localparam int unsigned PHY_ADDR_W  = 4;

  typedef enum logic [2:0] {
    PSI_IDLE  = 3'b000,
    PSI_START = 3'b001,
    PSI_HDR   = 3'b010,
    PSI_TA    = 3'b011,
    PSI_DATA  = 3'b100
  } psi_state_t;

endpackage

// *** rtl/psi_reg_if.sv ***
`timescale 1ns/1ns
`default_nettype none

interface psi_reg_if;
  logic        rd_stb;
  logic [4:0]  addr;
  logic [15:0] rdata;

  modport master (
    output rd_stb,
    output addr,
    input  rdata
  );

  modport bank (
    input  rd_stb,
    input  addr,
    output rdata
  );
endinterface

`default_nettype wire

// *** rtl/psi_bank.sv ***
`timescale 1ns/1ns
`default_nettype none

module psi_bank #(
  parameter logic [psi_pkg::OUI_W-1:0]   OUI_VALUE   = 22'h2a5a5c,
  parameter logic [psi_pkg::MODEL_W-1:0] MODEL_VALUE = 6'h1c,
  parameter logic [psi_pkg::REV_W-1:0]   REV_VALUE   = 4'h7
) (
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  sw_clear,
  input  wire logic  link_up,
  input  wire logic  remote_fault,
  input  wire logic  jabber,
  psi_reg_if.bank    bus
);
  import psi_pkg::*;

  logic        rfault_reg;
  logic        link_reg;
  logic        jabber_reg;
  logic        rfault_next;
  logic        link_next;
  logic        jabber_next;
  logic        read_status;
  logic [15:0] status_word;
  logic [15:0] id_upper_word;
  logic [15:0] id_lower_word;

  // ******************************************************
  // latched status bits
  // ******************************************************
  assign read_status = bus.rd_stb && (bus.addr == ADDR_BASIC_STATUS);

  // an event in the read cycle reloads the latch, so only a coincident sw_clear loses it
  assign rfault_next = sw_clear    ? RFAULT_RST :
                       read_status ? remote_fault :
                       (rfault_reg | remote_fault);
  assign jabber_next = sw_clear    ? JABBER_RST :
                       read_status ? jabber :
                       (jabber_reg | jabber);
  // a drop during the read cycle still lands as zero
  assign link_next   = sw_clear    ? LINK_RST :
                       read_status ? link_up :
                       (link_reg & link_up);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rfault_reg <= RFAULT_RST;
      link_reg   <= LINK_RST;
      jabber_reg <= JABBER_RST;
    end
    else
    begin
      rfault_reg <= rfault_next;
      link_reg   <= link_next;
      jabber_reg <= jabber_next;
    end
  end

  // ******************************************************
  // read words
  // ******************************************************
  assign status_word = (16'h0000 & BS_FIXED_ZERO_MASK)
                     | (16'h0001 << BS_PRE_SUPP_BIT)
                     | (16'h0001 << BS_NEG_DONE_BIT)
                     | (16'(rfault_reg) << BS_RFAULT_BIT)
                     | (16'(link_reg) << BS_LINK_BIT)
                     | (16'(jabber_reg) << BS_JABBER_BIT)
                     | (16'h0001 << BS_EXT_CAP_BIT);

  assign id_upper_word = OUI_VALUE[OUI_HI_MSB:OUI_HI_LSB];
  assign id_lower_word = {OUI_VALUE[OUI_LO_MSB:0],
                          MODEL_VALUE, REV_VALUE};

  // unmapped addresses read zero
  assign bus.rdata = (bus.addr == ADDR_BASIC_STATUS) ? status_word   :
                     (bus.addr == ADDR_ID_UPPER)     ? id_upper_word :
                     (bus.addr == ADDR_ID_LOWER)     ? id_lower_word :
                     16'h0000;

endmodule

`default_nettype wire

// *** tb/psi_mgmt_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module psi_mgmt_host (
  input  wire logic mclk,
  input  wire logic mdio,
  output var  logic mdc,
  output var  logic host_out,
  output var  logic host_oe
);
  // ********
  // station side: mdc low 5, high 5 mclk, idles low between frames
  // ********
  initial
  begin
    mdc = 1'b0;
    host_out = 1'b0;
    host_oe = 1'b0;
  end

  // data moves while mdc is low, sampled as mdc rises
  task automatic tick(input logic en, input logic v, output logic s);
    @(posedge mclk);
    #1;
    host_oe = en;
    host_out = v;
    mdc = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    s = mdio;
    mdc = 1'b1;
    repeat (4) @(posedge mclk);
  endtask

  // any opcode other than read is sent like a write
  task automatic frame(input logic pre, input logic [1:0] op,
                       input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic        s;
    logic        rdf;
    logic [13:0] hdr;
    hdr = {2'b01, op, pa, ra};
    rdf = (op == 2'b10);
    rd = 16'h0000;
    if (pre)
      repeat (32) tick(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      tick(1'b1, hdr[i], s);
    tick(!rdf, 1'b1, s);
    tick(!rdf, 1'b0, s);
    for (int i = 15; i >= 0; i--)
    begin
      tick(!rdf, wd[i], s);
      rd[i] = s;
    end
    @(posedge mclk);
    #1;
    host_oe = 1'b0;
    mdc = 1'b0;
  endtask
endmodule

`default_nettype wire

// *** tb/psi_status_regs_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none

module psi_status_regs_monitor #(
  parameter logic [psi_pkg::OUI_W-1:0]   OUI_VALUE   = 22'h000000,
  parameter logic [psi_pkg::MODEL_W-1:0] MODEL_VALUE = 6'h00,
  parameter logic [psi_pkg::REV_W-1:0]   REV_VALUE   = 4'h0,
  parameter int unsigned                 ADDR_W      = 4
) (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              mdc,
  input wire logic              mdio_in,
  input wire logic              mdio_out,
  input wire logic              mdio_oe,
  input wire logic [ADDR_W-1:0] phy_addr_strap,
  input wire logic              sw_clear,
  input wire logic              link_up,
  input wire logic              remote_fault,
  input wire logic              jabber
);
  import psi_pkg::*;
  // ********
  // mdc edge tracking and bit position
  // ********
  localparam logic [15:0] BS_ONE   = 16'h0061;
  localparam logic [15:0] BS_CONST = BS_FIXED_ZERO_MASK | BS_ONE;
  logic        mdc_d;
  logic        oe_d;
  logic        mdc_rise;
  logic        slot;
  logic [7:0]  since_rise;
  logic [4:0]  rise_cnt;
  logic [13:0] sh;
  logic [4:0]  rd_addr;
  logic [3:0]  bit_idx;
  logic [15:0] exp_word;
  assign mdc_rise = mdc && !mdc_d;
  assign bit_idx = 4'(5'h10 - rise_cnt);
  // look well after the device's shift, well before the next rise
  assign slot = mdio_oe && since_rise == 8'h06 && rise_cnt != 5'h00
                && rise_cnt <= 5'h10;
  assign exp_word = (rd_addr == ADDR_ID_UPPER) ? OUI_VALUE[21:6]
                    : {OUI_VALUE[5:0], MODEL_VALUE, REV_VALUE};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mdc_d <= 1'b0;
      oe_d <= 1'b0;
      since_rise <= 8'hff;
      rise_cnt <= 5'h00;
      sh <= 14'h0000;
      rd_addr <= 5'h00;
    end
    else
    begin
      mdc_d <= mdc;
      oe_d <= mdio_oe;
      if (mdc_rise)
        since_rise <= 8'h00;
      else if (since_rise != 8'hff)
        since_rise <= since_rise + 8'h01;
      if (mdio_oe && !oe_d)
        rise_cnt <= 5'h00;
      else if (mdc_rise)
        rise_cnt <= rise_cnt + 5'h01;
      if (mdc_rise)
        sh <= {sh[12:0], mdio_in};
      if (mdio_oe && !oe_d)
        rd_addr <= sh[5:1];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_rst_quiet;
    $rose(rst_n) |-> (!mdio_oe && !mdio_out) [*8];
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("drive after reset");
  property p_ta_zero;
    $rose(mdio_oe) |-> !mdio_out;
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
  property p_addr_match;
    $rose(mdio_oe) |-> sh[12:11] == OP_READ && sh[10:6] == 5'(phy_addr_strap);
  endproperty
  a_addr_match: assert property (p_addr_match) else $error("bad drive");
  property p_oe_len;
    $fell(mdio_oe) |-> rise_cnt == 5'h11;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("word length");
  property p_oe_max;
    mdio_oe && oe_d |-> rise_cnt <= 5'h11;
  endproperty
  a_oe_max: assert property (p_oe_max) else $error("drive too long");
  property p_on_mdc;
    $changed(mdio_out) || $changed(mdio_oe) |-> since_rise <= 8'h05;
  endproperty
  a_on_mdc: assert property (p_on_mdc) else $error("change off mdc");
  property p_status_fixed;
    slot && rd_addr == ADDR_BASIC_STATUS && BS_CONST[bit_idx]
      |-> mdio_out == BS_ONE[bit_idx];
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status bit");
  property p_id_value;
    slot && (rd_addr == ADDR_ID_UPPER || rd_addr == ADDR_ID_LOWER)
      |-> mdio_out == exp_word[bit_idx];
  endproperty
  a_id_value: assert property (p_id_value) else $error("id bit");
endmodule

bind psi_status_regs psi_status_regs_monitor #(
  .OUI_VALUE(OUI_VALUE), .MODEL_VALUE(MODEL_VALUE),
  .REV_VALUE(REV_VALUE), .ADDR_W(ADDR_W)
) i_mon (
  .mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr_strap(phy_addr_strap),
  .sw_clear(sw_clear), .link_up(link_up), .remote_fault(remote_fault),
  .jabber(jabber)
);

`default_nettype wire

// *** tb/psi_status_regs_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module psi_status_regs_tb_top;
  import psi_pkg::*;
  // identifier values are arbitrary
  localparam logic [21:0] OUI   = 22'h0b3d17;
  localparam logic [5:0]  MODEL = 6'h2b;
  localparam logic [3:0]  REV   = 4'h9;
  localparam logic [3:0]  STRAP = 4'h5;
  logic        mclk, rst_n, mdc, mdio, dut_out, dut_oe, h_out, h_oe;
  logic        sw_clear, link_up, remote_fault, jabber;
  logic [15:0] rd;
  int          num_errors = 0;
  int          cmp_count = 0;
  // ********
  // pull-up on the shared data line
  // ********
  assign mdio = dut_oe ? dut_out : (h_oe ? h_out : 1'b1);
  always #5 mclk = ~mclk;

  psi_status_regs #(.OUI_VALUE(OUI), .MODEL_VALUE(MODEL), .REV_VALUE(REV))
    i_dut (.mclk(mclk), .rst_n(rst_n), .mdc(mdc), .mdio_in(mdio),
           .mdio_out(dut_out), .mdio_oe(dut_oe), .phy_addr_strap(STRAP),
           .sw_clear(sw_clear), .link_up(link_up),
           .remote_fault(remote_fault), .jabber(jabber));
  psi_mgmt_host i_host (.mclk(mclk), .mdio(mdio), .mdc(mdc),
                        .host_out(h_out), .host_oe(h_oe));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic rd_reg(input logic pre, input logic [4:0] ra);
    i_host.frame(pre, OP_READ, 5'(STRAP), ra, 16'h0000, rd);
  endtask
  task automatic drive_ev(input logic rf, jb, lk, clr);
    @(posedge mclk);
    #1;
    remote_fault = rf;
    jabber = jb;
    link_up = lk;
    sw_clear = clr;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset_vals();
    rd_reg(1'b1, ADDR_BASIC_STATUS);
    check(rd, 16'h0065);
  endtask
  task automatic t_ids();
    rd_reg(1'b0, ADDR_ID_UPPER);
    check(rd, OUI[21:6]);
    rd_reg(1'b0, ADDR_ID_LOWER);
    check(rd, {OUI[5:0], MODEL, REV});
  endtask
  task automatic t_latch();
    drive_ev(1'b1, 1'b1, 1'b0, 1'b0);
    drive_ev(1'b0, 1'b0, 1'b1, 1'b0);
    rd_reg(1'b0, ADDR_BASIC_STATUS);
    check(rd, 16'h0073);
    rd_reg(1'b0, ADDR_BASIC_STATUS);
    check(rd, 16'h0065);
  endtask
  task automatic t_writes();
    drive_ev(1'b0, 1'b1, 1'b1, 1'b0);
    drive_ev(1'b0, 1'b0, 1'b1, 1'b0);
    i_host.frame(1'b0, OP_WRITE, 5'(STRAP), ADDR_BASIC_STATUS, 16'h0000, rd);
    i_host.frame(1'b0, OP_WRITE, 5'(STRAP), ADDR_ID_UPPER, 16'hffff, rd);
    rd_reg(1'b0, ADDR_BASIC_STATUS);
    check(rd, 16'h0067);
    rd_reg(1'b0, ADDR_ID_UPPER);
    check(rd, OUI[21:6]);
  endtask
  task automatic t_refuse();
    // a bad opcode drops preamble lock, so the bare read is ignored
    for (int i = 0; i < 2; i++)
    begin
      i_host.frame(1'b1, 2'(3 * i), 5'(STRAP), 5'h02, 16'h0000, rd);
      rd_reg(1'b0, ADDR_ID_UPPER);
      check(rd, 16'hffff);
    end
    i_host.frame(1'b1, OP_READ, 5'(STRAP) ^ 5'h01, 5'h02, 16'h0000, rd);
    check(rd, 16'hffff);
    rd_reg(1'b1, 5'h05);
    check(rd, 16'h0000);
    rd_reg(1'b0, ADDR_ID_LOWER);
    check(rd, {OUI[5:0], MODEL, REV});
  endtask
  task automatic t_swclr();
    drive_ev(1'b1, 1'b1, 1'b1, 1'b0);
    drive_ev(1'b0, 1'b0, 1'b1, 1'b1);
    drive_ev(1'b0, 1'b0, 1'b1, 1'b0);
    rd_reg(1'b0, ADDR_BASIC_STATUS);
    check(rd, 16'h0065);
  endtask

  initial
  begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    final_report();
  end

  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sw_clear = 1'b0;
    link_up = 1'b1;
    remote_fault = 1'b0;
    jabber = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (12) @(posedge mclk);
    t_reset_vals();
    t_ids();
    t_latch();
    t_writes();
    t_refuse();
    t_swclr();
    final_report();
  end
endmodule

`default_nettype wire
